// >>> core/sbc_bus_sense.sv
// Detector of START and STOP conditions and of bus occupancy.
// Assumes SCL and SDA levels synchronous to core_clk.
`timescale 1ns/100ps
module sbc_bus_sense (
    input wire logic core_clk,
    input wire logic sys_rst,
    sbc_sense_if.sensor sense
);
    logic sclPrev;
    logic sdaPrev;

    // Previous pin levels for edge detection
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sense.sclIn;
            sdaPrev <= sense.sdaIn;
        end
    end

    // SDA falls with SCL high: START; SDA rises with SCL high: STOP
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sense.startSeen <= 1'b0;
            sense.stopSeen <= 1'b0;
        end else begin
            sense.startSeen <= sclPrev && sense.sclIn && sdaPrev
                && !sense.sdaIn;
            sense.stopSeen <= sclPrev && sense.sclIn && !sdaPrev
                && sense.sdaIn;
        end
    end

    // Bus is busy from a START until the next STOP
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sense.busBusy <= 1'b0;
        end else if (sense.startSeen) begin
            sense.busBusy <= 1'b1;
        end else if (sense.stopSeen) begin
            sense.busBusy <= 1'b0;
        end
    end
endmodule

// >>> core/sbc_control_status.sv
// Control/status register and condition generator of a two-wire bus port.
// Assumes a byte engine outside that shifts data and reports byte events;
// all inputs are synchronous to core_clk.
`timescale 1ns/100ps
module sbc_control_status (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfrAddr,
    input wire logic [3:0] sfrPage,
    input wire logic sfrWe,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrBitWe,
    input wire logic [7:0] sfrBitAddr,
    input wire logic sfrBitVal,
    output logic [7:0] sfrRdata,
    output logic [7:0] ctrlStatus,
    output logic resumePulse,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic autoRespEn,
    input wire logic slaveAddressed,
    input wire logic shiftDataWrite,
    input wire logic frameBegin,
    input wire logic addrRxDone,
    input wire logic byteRxDone,
    input wire logic byteTxAcked,
    input wire logic ackSample,
    input wire logic ackCycleEnd,
    input wire logic ackPhase,
    input wire logic bitSample,
    input wire logic txBitHigh,
    input wire logic atBoundary,
    input wire logic engineSclLow,
    input wire logic engineSdaLow
);
    sbc_pkg::sbc_gen_t genState;
    sbc_pkg::sbc_gen_t next_genState;
    logic [7:0] holdCnt;
    logic initiator, txDir, beginReq, endReq;
    logic respNeeded, lost, resp, intFlag;
    logic dataWritten;
    logic byteHit, bitHit;
    logic [7:0] swMask, swData;
    logic holdDone, genStartDone, genStopDone, genSclFault;
    logic foreignStart, unwantedRs, sdaFault, lostByStop, lostNow;
    logic slaveStop, intClearWr;
    sbc_sense_if senseBus();

    // SCL is pulled low by the generator in these steps
    function automatic logic genPullsScl(input sbc_pkg::sbc_gen_t st);
        return (st == sbc_pkg::GEN_START_SCL) ||
            (st == sbc_pkg::GEN_STOP_SDA) || (st == sbc_pkg::GEN_RS_SDA);
    endfunction

    // SDA is pulled low by the generator in these steps
    function automatic logic genPullsSda(input sbc_pkg::sbc_gen_t st);
        return (st == sbc_pkg::GEN_START_SDA) ||
            (st == sbc_pkg::GEN_START_SCL) ||
            (st == sbc_pkg::GEN_STOP_SDA) || (st == sbc_pkg::GEN_STOP_SCL);
    endfunction

    // Bus condition detector
    assign senseBus.sclIn = sclIn;
    assign senseBus.sdaIn = sdaIn;
    sbc_bus_sense u_sense (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .sense(senseBus)
    );

    // Register decode: byte writes and single-bit writes, page checked
    assign byteHit = sfrWe && (sfrPage == sbc_pkg::CTRL_PAGE)
        && (sfrAddr == sbc_pkg::CTRL_ADDR);
    assign bitHit = sfrBitWe && (sfrPage == sbc_pkg::CTRL_PAGE)
        && ({sfrBitAddr[7:3], 3'h0} == sbc_pkg::CTRL_ADDR);
    always_comb begin
        swMask = 8'h00;
        swData = sfrWdata;
        if (byteHit) begin
            swMask = sbc_pkg::SW_WRITE_MASK;
        end else if (bitHit) begin
            swMask = sbc_pkg::SW_WRITE_MASK & (8'h01 << sfrBitAddr[2:0]);
            swData = {8{sfrBitVal}};
        end
    end
    assign intClearWr = swMask[sbc_pkg::BIT_INT] && !swData[sbc_pkg::BIT_INT];

    // Bus events derived from the generator and the detector
    assign holdDone = (holdCnt == sbc_pkg::HOLD_LAST);
    assign genStartDone = (genState == sbc_pkg::GEN_START_SCL) && holdDone;
    assign genStopDone = (genState == sbc_pkg::GEN_STOP_END) && holdDone;
    assign genSclFault = ((genState == sbc_pkg::GEN_STOP_SCL) ||
        (genState == sbc_pkg::GEN_RS_SCL)) && holdDone && !sclIn;
    assign foreignStart = senseBus.startSeen
        && (genState == sbc_pkg::GEN_IDLE);
    assign unwantedRs = foreignStart && initiator && !beginReq;
    assign sdaFault = bitSample && txBitHigh && !sdaIn;
    assign lostByStop = senseBus.stopSeen && initiator
        && (genState == sbc_pkg::GEN_IDLE);
    assign lostNow = genSclFault || unwantedRs || sdaFault || lostByStop;
    assign slaveStop = senseBus.stopSeen && !initiator && slaveAddressed;

    // Generator step selection; leaving idle waits while the flag is set, other steps run on
    always_comb begin
        next_genState = genState;
        case (genState)
            sbc_pkg::GEN_IDLE: begin
                if (!intFlag) begin
                    if (endReq && initiator && atBoundary) begin
                        next_genState = sbc_pkg::GEN_STOP_SDA;
                    end else if (beginReq && initiator && atBoundary) begin
                        next_genState = sbc_pkg::GEN_RS_SDA;
                    end else if (beginReq && !initiator
                            && !senseBus.busBusy) begin
                        next_genState = sbc_pkg::GEN_START_SDA;
                    end
                end
            end
            sbc_pkg::GEN_START_SDA: begin
                if (holdDone) next_genState = sbc_pkg::GEN_START_SCL;
            end
            sbc_pkg::GEN_START_SCL: begin
                if (holdDone) next_genState = sbc_pkg::GEN_IDLE;
            end
            sbc_pkg::GEN_STOP_SDA: begin
                if (holdDone) next_genState = sbc_pkg::GEN_STOP_SCL;
            end
            sbc_pkg::GEN_STOP_SCL: begin
                if (genSclFault) next_genState = sbc_pkg::GEN_IDLE;
                else if (holdDone) next_genState = sbc_pkg::GEN_STOP_END;
            end
            sbc_pkg::GEN_STOP_END: begin
                if (holdDone) next_genState = sbc_pkg::GEN_IDLE;
            end
            sbc_pkg::GEN_RS_SDA: begin
                if (holdDone) next_genState = sbc_pkg::GEN_RS_SCL;
            end
            sbc_pkg::GEN_RS_SCL: begin
                if (genSclFault) next_genState = sbc_pkg::GEN_IDLE;
                else if (holdDone) next_genState = sbc_pkg::GEN_START_SDA;
            end
            default: next_genState = sbc_pkg::GEN_IDLE;
        endcase
    end

    // Generator state and per-step hold counter
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            genState <= sbc_pkg::GEN_IDLE;
            holdCnt <= sbc_pkg::HOLD_ZERO;
        end else begin
            genState <= next_genState;
            if (next_genState != genState || genState == sbc_pkg::GEN_IDLE)
                holdCnt <= sbc_pkg::HOLD_ZERO;
            else
                holdCnt <= holdCnt + 8'h01;
        end
    end

    // Master role indicator
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            initiator <= 1'b0;
        end else if (genStartDone) begin
            initiator <= 1'b1;
        end else if (genStopDone || lostNow) begin
            initiator <= 1'b0;
        end
    end

    // Data register written since the last frame began
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dataWritten <= 1'b0;
        end else if (shiftDataWrite) begin
            dataWritten <= 1'b1;
        end else if (frameBegin) begin
            dataWritten <= 1'b0;
        end
    end

    // Transmit direction
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txDir <= 1'b0;
        end else if (genStartDone || (frameBegin && dataWritten)) begin
            txDir <= 1'b1;
        end else if (foreignStart || lostNow
                || (frameBegin && !dataWritten)) begin
            txDir <= 1'b0;
        end
    end

    // Begin request: set by hardware, cleared only by software
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            beginReq <= 1'b0;
        end else if (addrRxDone && !initiator) begin
            beginReq <= 1'b1;
        end else if (swMask[sbc_pkg::BIT_BEGIN]) begin
            beginReq <= swData[sbc_pkg::BIT_BEGIN];
        end
    end

    // End request: stop seen as slave or lost to a stop; pending as master
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            endReq <= 1'b0;
        end else if (slaveStop || lostByStop) begin
            endReq <= 1'b1;
        end else if (genStopDone) begin
            endReq <= 1'b0;
        end else if (swMask[sbc_pkg::BIT_END]) begin
            endReq <= swData[sbc_pkg::BIT_END];
        end
    end

    // Response needed after a received byte when acks are manual
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            respNeeded <= 1'b0;
        end else if (byteRxDone && !autoRespEn) begin
            respNeeded <= 1'b1;
        end else if (ackCycleEnd) begin
            respNeeded <= 1'b0;
        end
    end

    // Lost contention; any clear of the interrupt flag clears it
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lost <= 1'b0;
        end else if (lostNow) begin
            lost <= 1'b1;
        end else if (intClearWr) begin
            lost <= 1'b0;
        end
    end

    // Response bit: sampled ack, software value, default NACK on receive
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            resp <= 1'b0;
        end else if (ackSample) begin
            resp <= !sdaIn;
        end else if (swMask[sbc_pkg::BIT_RESP]) begin
            resp <= swData[sbc_pkg::BIT_RESP];
        end else if (byteRxDone && !autoRespEn) begin
            resp <= 1'b0;
        end
    end

    // Interrupt flag: hardware events win over a software write
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            intFlag <= 1'b0;
        end else if (genStartDone || lostNow || byteTxAcked
                || byteRxDone) begin
            intFlag <= 1'b1;
        end else if (addrRxDone || slaveStop) begin
            intFlag <= 1'b1;
        end else if (swMask[sbc_pkg::BIT_INT]) begin
            intFlag <= swData[sbc_pkg::BIT_INT];
        end
    end

    // Advance strobe to the byte engine when software clears the flag
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            resumePulse <= 1'b0;
        end else begin
            resumePulse <= intClearWr;
        end
    end

    // Register image and read port
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sfrRdata <= sbc_pkg::CTRL_RESET;
        end else if ((sfrPage == sbc_pkg::CTRL_PAGE)
                && (sfrAddr == sbc_pkg::CTRL_ADDR)) begin
            sfrRdata <= {initiator, txDir, beginReq, endReq,
                respNeeded, lost, resp, intFlag};
        end else begin
            sfrRdata <= 8'h00;
        end
    end
    assign ctrlStatus = {initiator, txDir, beginReq, endReq,
        respNeeded, lost, resp, intFlag};

    // Open-drain pins: enable low means the pin is pulled low
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclOe <= 1'b1;
            sdaOe <= 1'b1;
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
        end else begin
            sclOe <= !(intFlag || genStartDone
                || genPullsScl(next_genState) || engineSclLow);
            sdaOe <= !(genPullsSda(next_genState) || engineSdaLow
                || (ackPhase && resp));
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    property p_master_set;
        genStartDone |=> initiator && ctrlStatus[7];
    endproperty
    a_master_set: assert property (p_master_set)
        else $error("master bit not set after START");

    property p_master_clear;
        (genStopDone || lostNow) |=> !initiator;
    endproperty
    a_master_clear: assert property (p_master_clear)
        else $error("master bit not cleared");

    property p_txdir_clear;
        (foreignStart && !genStartDone && !frameBegin) |=> !txDir;
    endproperty
    a_txdir_clear: assert property (p_txdir_clear)
        else $error("transmit bit kept after detected START");

    property p_lost_clear;
        (intClearWr && !lostNow) |=> !lost ##1 !lost || $past(lostNow, 1);
    endproperty
    a_lost_clear: assert property (p_lost_clear)
        else $error("loss flag kept after interrupt clear");

    property p_scl_hold;
        intFlag |=> !sclOe;
    endproperty
    a_scl_hold: assert property (p_scl_hold)
        else $error("SCL released while interrupt set");

    property p_stall;
        (intFlag && genState == sbc_pkg::GEN_IDLE) |=>
            genState == sbc_pkg::GEN_IDLE;
    endproperty
    a_stall: assert property (p_stall)
        else $error("generator moved while interrupt set");

    property p_resp_sample;
        ackSample |=> resp == !$past(sdaIn);
    endproperty
    a_resp_sample: assert property (p_resp_sample)
        else $error("response bit does not match sampled ack");

    property p_respneed;
        (byteRxDone && !autoRespEn) |=> respNeeded && intFlag;
    endproperty
    a_respneed: assert property (p_respneed)
        else $error("response-needed not set after received byte");

    property p_end_clear;
        (genStopDone && !slaveStop && !lostByStop) |=> !endReq;
    endproperty
    a_end_clear: assert property (p_end_clear)
        else $error("end request kept after STOP generated");

    property p_busy_wait;
        (genState == sbc_pkg::GEN_IDLE && !initiator && senseBus.busBusy)
            |=> genState != sbc_pkg::GEN_START_SDA;
    endproperty
    a_busy_wait: assert property (p_busy_wait)
        else $error("START begun on a busy bus");

    property p_stop_then_start;
        (genStopDone && beginReq && !lostNow) |=>
            !initiator ##[1:4] genState == sbc_pkg::GEN_START_SDA
            || intFlag || !beginReq;
    endproperty
    a_stop_then_start: assert property (p_stop_then_start)
        else $error("START not issued after STOP");

    property p_hw_wins;
        (byteRxDone && intClearWr) |=> intFlag;
    endproperty
    a_hw_wins: assert property (p_hw_wins)
        else $error("software clear beat hardware set");
endmodule

// >>> core/sbc_pkg.sv
// Constants and types shared by the serial bus control/status block.
// Assumes a 50 MHz core clock; no other package is needed.
package sbc_pkg;

    // Location of the control/status register on the SFR bus
    localparam logic [7:0] CTRL_ADDR = 8'hC0;
    localparam logic [3:0] CTRL_PAGE = 4'h0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Field positions inside the control/status register
    localparam int unsigned BIT_INITIATOR = 7;
    localparam int unsigned BIT_TXDIR = 6;
    localparam int unsigned BIT_BEGIN = 5;
    localparam int unsigned BIT_END = 4;
    localparam int unsigned BIT_RESPNEED = 3;
    localparam int unsigned BIT_LOST = 2;
    localparam int unsigned BIT_RESP = 1;
    localparam int unsigned BIT_INT = 0;

    // Bits that software may change; the rest are read-only
    localparam logic [7:0] SW_WRITE_MASK = 8'h33;

    // Hold time of each step of a START or STOP condition
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned COND_HOLD_NS = 4000;
    localparam int unsigned HOLD_CYCLES =
        (COND_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYCLES - 1);
    localparam logic [7:0] HOLD_ZERO = 8'h00;

    // Steps of the START / STOP / repeated START generator
    typedef enum logic [2:0] {
        GEN_IDLE = 3'b000,
        GEN_START_SDA = 3'b001,
        GEN_START_SCL = 3'b010,
        GEN_STOP_SDA = 3'b011,
        GEN_STOP_SCL = 3'b100,
        GEN_STOP_END = 3'b101,
        GEN_RS_SDA = 3'b110,
        GEN_RS_SCL = 3'b111
    } sbc_gen_t;

endpackage

// >>> core/sbc_sense_if.sv
// Connection between the control block and its bus condition detector.
// Assumes pin levels already synchronous to core_clk.
`timescale 1ns/100ps
interface sbc_sense_if;
    logic sclIn;
    logic sdaIn;
    logic startSeen;
    logic stopSeen;
    logic busBusy;
    modport sensor(input sclIn, input sdaIn,
        output startSeen, output stopSeen, output busBusy);
    modport user(output sclIn, output sdaIn,
        input startSeen, input stopSeen, input busBusy);
endinterface

// >>> verif/sbc_bus_peer.sv
// Far side of the two-wire bus: pull-ups and one other device.
// Assumes the block's enables are low while it pulls a pin low.
`timescale 1ns/100ps
module sbc_bus_peer (
    input wire logic sclOe,
    input wire logic sdaOe,
    input wire logic pullScl,
    input wire logic pullSda,
    output logic sclLine,
    output logic sdaLine
);
    // Wired-AND with pull-ups, so a released line reads high
    assign sclLine = sclOe & ~pullScl;
    assign sdaLine = sdaOe & ~pullSda;
endmodule

// >>> verif/smbus_control_status_test.sv
// Self-checking bench of the serial bus control/status block.
// Assumes the design in core/ and the bus peer model in verif/.
`timescale 1ns/100ps
module smbus_control_status_test;
    logic core_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [7:0] sfrAddr = 8'hC0;
    logic [3:0] sfrPage = 4'h0;
    logic sfrWe = 1'h0;
    logic [7:0] sfrWdata = 8'h00;
    logic sfrBitWe = 1'h0;
    logic [7:0] sfrBitAddr = 8'hC0;
    logic sfrBitVal = 1'h0;
    logic [14:0] eng = 15'h0000;
    logic pullSda = 1'h0;
    logic [7:0] sfrRdata, ctrlStatus;
    logic resumePulse, sclOut, sclOe, sdaOut, sdaOe, sclLine, sdaLine;
    int error_cnt = 0;
    int num_checks = 0;
    logic [7:0] resumes = 8'h00;

    // Free-running core clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // Count advance strobes handed to the byte engine
    always @(posedge core_clk) begin
        if (resumePulse === 1'h1) resumes <= resumes + 8'h01;
    end

    sbc_control_status u_sbc_control_status (
        .core_clk(core_clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr),
        .sfrPage(sfrPage), .sfrWe(sfrWe), .sfrWdata(sfrWdata),
        .sfrBitWe(sfrBitWe), .sfrBitAddr(sfrBitAddr),
        .sfrBitVal(sfrBitVal), .sfrRdata(sfrRdata),
        .ctrlStatus(ctrlStatus), .resumePulse(resumePulse),
        .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .autoRespEn(eng[0]), .slaveAddressed(eng[1]),
        .shiftDataWrite(eng[2]), .frameBegin(eng[3]),
        .addrRxDone(eng[4]), .byteRxDone(eng[5]),
        .byteTxAcked(eng[6]), .ackSample(eng[7]),
        .ackCycleEnd(eng[8]), .ackPhase(eng[9]), .bitSample(eng[10]),
        .txBitHigh(eng[11]), .atBoundary(eng[12]),
        .engineSclLow(eng[13]), .engineSdaLow(eng[14]));

    sbc_bus_peer u_sbc_bus_peer (
        .sclOe(sclOe), .sdaOe(sdaOe), .pullScl(1'h0),
        .pullSda(pullSda), .sclLine(sclLine), .sdaLine(sdaLine));

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    task automatic st(input string what, input logic [7:0] mask,
            input logic [7:0] exp);
        chk(what, exp, ctrlStatus & mask);
    endtask

    // Byte write (bitMode 0) or single-bit write (bitMode 1)
    task automatic wr(input logic bitMode, input logic [7:0] a,
            input logic [7:0] d);
        @(posedge core_clk);
        sfrWe <= ~bitMode;
        sfrBitWe <= bitMode;
        sfrAddr <= bitMode ? 8'hC0 : a;
        sfrBitAddr <= a;
        sfrWdata <= d;
        sfrBitVal <= d[0];
        @(posedge core_clk);
        sfrWe <= 1'h0;
        sfrBitWe <= 1'h0;
        tick(2);
    endtask

    task automatic pulse(input int b);
        @(posedge core_clk);
        eng[b] <= 1'h1;
        @(posedge core_clk);
        eng[b] <= 1'h0;
        tick(2);
    endtask

    task automatic waitBit(input int b, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && ctrlStatus[b] !== v; i++) tick(1);
        if (i == lim) begin
            $display("Error wait bit %0d expected %b seen %b", b, v,
                ctrlStatus[b]);
            error_cnt++;
            close_out();
        end
    endtask

    task automatic test_reset();
        st("reset", 8'hFF, 8'h00);
        wr(0, 8'hC0, 8'hCC);
        st("readonly", 8'hFF, 8'h00);
        wr(0, 8'hC0, 8'h01);
        tick(1);
        st("force", 8'hFF, 8'h01);
        chk("read", 8'h01, sfrRdata);
        chk("sclHeld", 8'h00, {7'h00, sclOe});
        @(posedge core_clk);
        sfrAddr <= 8'hC1;
        tick(2);
        chk("unmapped", 8'h00, sfrRdata);
        wr(1, 8'hC0, 8'h00);
        st("clear", 8'hFF, 8'h00);
        chk("resume", 8'h02, resumes);
        chk("odPins", 8'h00, {6'h00, sdaOut, sclOut});
        $display("reset test done");
    endtask

    task automatic test_master();
        wr(1, 8'hC5, 8'h01);
        tick(100);
        chk("startPins", 8'h01, {6'h00, sdaOe, sclOe});
        waitBit(7, 1'h1, 500);
        st("started", 8'hFF, 8'hE1);
        wr(1, 8'hC5, 8'h00);
        @(posedge core_clk);
        eng[12] <= 1'h1;
        wr(1, 8'hC4, 8'h01);
        wr(1, 8'hC0, 8'h00);
        waitBit(7, 1'h0, 800);
        st("stopped", 8'h91, 8'h00);
        chk("stopPins", 8'h03, {6'h00, sdaOe, sclOe});
        @(posedge core_clk);
        eng[12] <= 1'h0;
        $display("master test done");
    endtask

    task automatic test_bytes();
        @(posedge core_clk);
        eng[5] <= 1'h1;
        sfrBitWe <= 1'h1;
        sfrBitAddr <= 8'hC0;
        sfrBitVal <= 1'h0;
        @(posedge core_clk);
        eng[5] <= 1'h0;
        sfrBitWe <= 1'h0;
        tick(2);
        st("rxByte", 8'h0B, 8'h09);
        pulse(8);
        st("ackEnd", 8'h08, 8'h00);
        @(posedge core_clk);
        pullSda <= 1'h1;
        pulse(7);
        st("ackLow", 8'h02, 8'h02);
        @(posedge core_clk);
        pullSda <= 1'h0;
        pulse(7);
        st("ackHigh", 8'h02, 8'h00);
        pulse(3);
        st("noData", 8'h40, 8'h00);
        pulse(2);
        pulse(3);
        st("txData", 8'h40, 8'h40);
        wr(1, 8'hC0, 8'h00);
        pulse(6);
        st("txAcked", 8'h01, 8'h01);
        pulse(2);
        pulse(3);
        @(posedge core_clk);
        eng[11] <= 1'h1;
        pullSda <= 1'h1;
        pulse(10);
        st("lost", 8'hC5, 8'h05);
        @(posedge core_clk);
        eng[11] <= 1'h0;
        pullSda <= 1'h0;
        wr(1, 8'hC0, 8'h00);
        st("lostClr", 8'h05, 8'h00);
        $display("byte test done");
    endtask

    task automatic test_slave();
        pulse(2);
        pulse(3);
        @(posedge core_clk);
        eng[1] <= 1'h1;
        pullSda <= 1'h1;
        tick(5);
        pulse(4);
        st("addr", 8'h61, 8'h21);
        wr(1, 8'hC5, 8'h00);
        wr(1, 8'hC0, 8'h00);
        @(posedge core_clk);
        pullSda <= 1'h0;
        waitBit(4, 1'h1, 20);
        st("slaveStop", 8'h11, 8'h11);
        @(posedge core_clk);
        eng[1] <= 1'h0;
        wr(0, 8'hC0, 8'h00);
        $display("slave test done");
    endtask

    task automatic test_arb();
        @(posedge core_clk);
        pullSda <= 1'h1;
        wr(1, 8'hC5, 8'h01);
        tick(50);
        chk("busyWait", 8'h03, {6'h00, sdaOe, sclOe});
        @(posedge core_clk);
        pullSda <= 1'h0;
        waitBit(7, 1'h1, 500);
        st("freeStart", 8'hFF, 8'hE1);
        @(posedge core_clk);
        eng[12] <= 1'h1;
        wr(1, 8'hC4, 8'h01);
        wr(1, 8'hC0, 8'h00);
        waitBit(7, 1'h0, 800);
        st("stopFirst", 8'h10, 8'h00);
        waitBit(7, 1'h1, 500);
        st("thenStart", 8'hFF, 8'hE1);
        wr(1, 8'hC1, 8'h01);
        @(posedge core_clk);
        eng[9] <= 1'h1;
        tick(2);
        chk("ackDrive", 8'h00, {7'h00, sdaOe});
        @(posedge core_clk);
        eng[9] <= 1'h0;
        wr(1, 8'hC5, 8'h00);
        wr(1, 8'hC0, 8'h00);
        @(posedge core_clk);
        pullSda <= 1'h1;
        tick(3);
        st("unwanted", 8'hC5, 8'h05);
        @(posedge core_clk);
        pullSda <= 1'h0;
        eng[12] <= 1'h0;
        wr(0, 8'hC0, 8'h00);
        $display("arbitration test done");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'h0;
        tick(2);
        test_reset();
        test_master();
        test_bytes();
        test_slave();
        test_arb();
        close_out();
    end
endmodule
